// File: rtl/psi5_init_regs.vh
// Constants for the PSI5 initialization sequencer.
//
// Overview of operation
// - Three phases in order; phase 1 silent.
// - Set init_done_flag on leaving phase 3.
// - Asynchronous mode: frames for source 0 only.
// - Synchronous mode without daisy chain: frames for every enabled source.
// - Daisy chain: source 0 slot only.
// - Hold reference_pressure error until counter expires.
// - After initialization report range error immediately.
// - Phase 1: settle, watch programming entry window.
// - Phase 2: identifier then data, k repeats.
// - 32 or 48 nibbles; count in nibbles two, three.
// - Phase 2 lasts two frames times k times nibbles.
// - k is 8 asynchronous, 4 synchronous.
// - Serial, part and user nibbles at fixed positions.
// - Extended nibbles 33 to 48 send constants.
// - Self-test starts when phase 1 ends.
// - Busy frames during self-test; bounded retries.
// - Exactly two ready frames after self-test.
// - Latch reference_pressure at second ready frame.
// - Four pressure frames: index then three bits.
// - Data nibble and identifier code tables.
// - Busy, ready and unlocked status codes.

`ifndef PSI5_INIT_REGS_VH
`define PSI5_INIT_REGS_VH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_MHZ         100
`define T_POR_US        2000
`define T_PME_US        10000
`define T_ASYNC_US      228
`define T_P0_HOLD_MS    2000
`define POR_CYC         (`T_POR_US * `CLK_MHZ)
`define PME_CYC         (`T_PME_US * `CLK_MHZ)
`define ASYNC_CYC       (`T_ASYNC_US * `CLK_MHZ)
`define P0_HOLD_CYC     (`T_P0_HOLD_MS * 1000 * `CLK_MHZ)
`define TIMER_W         28

// ----------------------------------------------------------------
// Sequence figures
// ----------------------------------------------------------------
`define K_ASYNC         3'd7
`define K_SYNC          3'd3
`define NIB_STD_LAST    6'd31
`define NIB_EXT_LAST    6'd47
`define SN_FIRST        6'd18
`define SN_LAST         6'd27
`define RSVD_NIBBLE     4'h0
`define SRC0_MASK       4'h1

// ----------------------------------------------------------------
// Frame codes
// ----------------------------------------------------------------
`define CODE_DATA_TOP   10'h21f
`define CODE_ID_TOP     10'h20f
`define CODE_P0_BASE    10'h200
`define CODE_BUSY       10'h1e8
`define CODE_READY      10'h1e7
`define CODE_UNLOCKED   10'h1e6
`define CODE_ST_ERR     10'h1ea
`define CODE_P0_ERR     10'h1f4

`endif

// File: rtl/bit_sync2.v
// Two-flop synchroniser for a single level.
`timescale 1ns/10ps

module bit_sync2 (
  // Clock and reset
  input  wire mclk_i,
  input  wire sys_rst_i,
  // Level
  input  wire d_i,
  output reg  q_o
);

  reg meta;

  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      meta <= 1'b0;
      q_o  <= 1'b0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule // bit_sync2

// File: rtl/cycle_timer.v
// Cycle counter giving a tick after a set number of cycles.
`timescale 1ns/10ps

module cycle_timer #(
  parameter W = 28
) (
  // Clock and reset
  input  wire         mclk_i,
  input  wire         sys_rst_i,
  // Control
  input  wire         restart_i,
  input  wire         repeat_i,
  input  wire [W-1:0] limit_i,
  // Status
  output reg          tick_o,
  output reg          done_o
);

  reg [W-1:0] count;

  // In repeat mode the tick recurs every limit_i cycles; otherwise
  // the counter stops and done_o stays high until restarted.
  always @(posedge mclk_i) begin
    if (sys_rst_i || restart_i) begin
      count  <= {W{1'b0}};
      tick_o <= 1'b0;
      done_o <= 1'b0;
    end else if (done_o) begin
      tick_o <= 1'b0;
    end else if (count == limit_i - 1'b1) begin
      tick_o <= 1'b1;
      done_o <= ~repeat_i;
      count  <= {W{1'b0}};
    end else begin
      tick_o <= 1'b0;
      count  <= count + 1'b1;
    end
  end

endmodule // cycle_timer

// File: rtl/psi5_init_sequencer.v
// PSI5 power-up initialization sequencer, phases 1 to 3.
`timescale 1ns/10ps
`include "psi5_init_regs.vh"

module psi5_init_sequencer #(
  parameter [27:0] POR_CYC     = `POR_CYC,
  parameter [27:0] PME_CYC     = `PME_CYC,
  parameter [27:0] ASYNC_CYC   = `ASYNC_CYC,
  parameter [27:0] P0_HOLD_CYC = `P0_HOLD_CYC
) (
  // Clock and reset
  input  wire        mclk_i,
  input  wire        sys_rst_i,
  // Configuration
  input  wire        sync_mode_i,
  input  wire        daisy_chain_i,
  input  wire [3:0]  sid_enable_i,
  input  wire        phase2_extended_fields_i,
  input  wire [3:0]  selftest_retry_limit_i,
  input  wire        unlocked_i,
  // Bus events
  input  wire        sync_pulse_i,
  input  wire        pme_detect_i,
  input  wire        daisy_run_i,
  // Identification data
  input  wire [71:0] user_info_bytes_i,
  input  wire [39:0] serial_number_bytes_i,
  input  wire [15:0] part_number_bytes_i,
  // Pressure
  input  wire [11:0] reference_pressure_i,
  input  wire [11:0] p0_low_i,
  input  wire [11:0] p0_high_i,
  // Self-test engine
  input  wire        selftest_done_i,
  input  wire        selftest_pass_i,
  output reg         selftest_start_o,
  output reg         selftest_error_o,
  // Frame output
  output reg         frame_valid_o,
  output reg  [9:0]  frame_code_o,
  output reg  [3:0]  frame_sid_mask_o,
  // Status
  output reg  [2:0]  init_phase_o,
  output reg         init_done_flag_o,
  output reg         prog_mode_o,
  output reg         p0_error_o
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [7:0] S_POR    = 8'h01;
  localparam [7:0] S_PME    = 8'h02;
  localparam [7:0] S_PROG   = 8'h04;
  localparam [7:0] S_P2     = 8'h08;
  localparam [7:0] S_BUSY   = 8'h10;
  localparam [7:0] S_READY  = 8'h20;
  localparam [7:0] S_P0     = 8'h40;
  localparam [7:0] S_NORMAL = 8'h80;

  reg  [7:0]  state;
  reg  [7:0]  next_state;

  // Phase 2 position.
  reg  [5:0]  nib;
  reg  [2:0]  rep;
  reg         half;

  // Phase 3 position.
  reg         rdy_cnt;
  reg  [1:0]  p0_idx;
  reg  [11:0] p0_latch;

  // Self-test control.
  reg         st_run;
  reg         st_complete;
  reg  [3:0]  st_tries;

  // Pressure error hold.
  reg         p0_err_pend;

  reg         sync_prev;
  reg         p1_restart;
  reg         p1_tick_seen;

  wire        sync_lvl;
  wire        async_tick;
  wire        p1_tick;
  wire        hold_tick;

  // ----------------------------------------------------------------
  // Transmission opportunities
  // ----------------------------------------------------------------
  bit_sync2 u_sync (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .d_i       (sync_pulse_i),
    .q_o       (sync_lvl)
  );

  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      sync_prev <= 1'b0;
    end else begin
      sync_prev <= sync_lvl;
    end
  end

  cycle_timer #(
    .W (`TIMER_W)
  ) u_async (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .restart_i (1'b0),
    .repeat_i  (1'b1),
    .limit_i   (ASYNC_CYC),
    .tick_o    (async_tick),
    .done_o    ()
  );

  // Daisy chain always follows sync pulses.
  wire use_sync = sync_mode_i | daisy_chain_i;
  wire sync_rise = sync_lvl & ~sync_prev;
  wire opp = use_sync ? sync_rise : async_tick;

  wire [3:0] sid_mask = (sync_mode_i & ~daisy_chain_i) ?
                        sid_enable_i :
                        `SRC0_MASK;

  // ----------------------------------------------------------------
  // Phase 1 and pressure hold timers
  // ----------------------------------------------------------------
  cycle_timer #(
    .W (`TIMER_W)
  ) u_p1 (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .restart_i (p1_restart),
    .repeat_i  (1'b0),
    .limit_i   (state[0] ? POR_CYC : PME_CYC),
    .tick_o    (p1_tick),
    .done_o    ()
  );

  // Starts at reset release, is never restarted by the pressure.
  cycle_timer #(
    .W (`TIMER_W)
  ) u_hold (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .restart_i (1'b0),
    .repeat_i  (1'b0),
    .limit_i   (P0_HOLD_CYC),
    .tick_o    (hold_tick),
    .done_o    ()
  );

  wire p0_oor = (reference_pressure_i < p0_low_i) |
                (reference_pressure_i > p0_high_i);

  // ----------------------------------------------------------------
  // Phase 2 nibble content
  // ----------------------------------------------------------------
  wire [2:0]  k_last   = sync_mode_i ? `K_SYNC : `K_ASYNC;
  wire [5:0]  nib_last = phase2_extended_fields_i ?
                         `NIB_EXT_LAST : `NIB_STD_LAST;
  wire [5:0]  sn_off   = nib - `SN_FIRST;
  wire [39:0] sn_sh    = serial_number_bytes_i << {sn_off, 2'b00};

  reg  [3:0]  nib_val;

  always @* begin
    nib_val = `RSVD_NIBBLE;
    if (nib >= `SN_FIRST && nib <= `SN_LAST) begin
      nib_val = sn_sh[39:36];
    end else begin
      case (nib)
        6'd0:  nib_val = user_info_bytes_i[3:0];
        6'd1:  nib_val = {3'b001, phase2_extended_fields_i};
        6'd2:  nib_val = 4'h0;
        6'd3:  nib_val = user_info_bytes_i[11:8];
        6'd4:  nib_val = user_info_bytes_i[15:12];
        6'd5:  nib_val = user_info_bytes_i[19:16];
        6'd6:  nib_val = user_info_bytes_i[23:20];
        6'd7:  nib_val = user_info_bytes_i[27:24];
        6'd8:  nib_val = user_info_bytes_i[31:28];
        6'd9:  nib_val = user_info_bytes_i[35:32];
        6'd10: nib_val = user_info_bytes_i[39:36];
        6'd11: nib_val = user_info_bytes_i[43:40];
        6'd12: nib_val = user_info_bytes_i[47:44];
        6'd13: nib_val = user_info_bytes_i[51:48];
        6'd14: nib_val = user_info_bytes_i[59:56];
        6'd15: nib_val = user_info_bytes_i[63:60];
        6'd16: nib_val = user_info_bytes_i[67:64];
        6'd17: nib_val = user_info_bytes_i[71:68];
        6'd28: nib_val = part_number_bytes_i[11:8];
        6'd29: nib_val = part_number_bytes_i[7:4];
        6'd30: nib_val = part_number_bytes_i[3:0];
        6'd31: nib_val = user_info_bytes_i[55:52];
        default: nib_val = `RSVD_NIBBLE;
      endcase
    end
  end

  wire [9:0] data_code = `CODE_DATA_TOP - {6'h00, nib_val};
  wire [9:0] id_code   = `CODE_ID_TOP - {6'h00, nib[3:0]};

  // Pressure frame: two index bits then three value bits.
  reg  [2:0] p0_bits;

  always @* begin
    case (p0_idx)
      2'd0:    p0_bits = p0_latch[11:9];
      2'd1:    p0_bits = p0_latch[8:6];
      2'd2:    p0_bits = p0_latch[5:3];
      default: p0_bits = p0_latch[2:0];
    endcase
  end

  wire [9:0] p0_code = `CODE_P0_BASE | {5'h00, p0_idx, p0_bits};

  wire [9:0] ready_code = (st_complete & selftest_error_o) ? `CODE_ST_ERR :
                          unlocked_i ? `CODE_UNLOCKED :
                          `CODE_READY;

  // A held pressure error takes the next opportunity in phases 2, 3.
  wire err_slot = p0_err_pend & opp & (state[3] | state[4] | state[5] | state[6]);
  wire seq_opp  = opp & ~err_slot;
  wire p2_end   = half & (rep == k_last) & (nib == nib_last);

  // ----------------------------------------------------------------
  // Sequence state machine
  // ----------------------------------------------------------------
  always @* begin
    next_state = state;
    case (state)
      S_POR: begin
        if (p1_tick) begin
          next_state = S_PME;
        end
      end
      S_PME: begin
        if (pme_detect_i) begin
          next_state = S_PROG;
        end else if (p1_tick ||
                     (state[1] && daisy_chain_i && daisy_run_i)) begin
          next_state = S_PME;
        end
        if (!pme_detect_i && p1_tick_seen && (!daisy_chain_i || daisy_run_i)) begin
          next_state = S_P2;
        end
      end
      S_PROG: begin
        next_state = S_PROG;
      end
      S_P2: begin
        if (seq_opp && p2_end) begin
          next_state = S_BUSY;
        end
      end
      S_BUSY: begin
        if (seq_opp && st_complete) begin
          next_state = S_READY;
        end
      end
      S_READY: begin
        if (seq_opp && rdy_cnt) begin
          next_state = S_P0;
        end
      end
      S_P0: begin
        if (seq_opp && p0_idx == 2'd3) begin
          next_state = S_NORMAL;
        end
      end
      S_NORMAL: begin
        next_state = S_NORMAL;
      end
      default: begin
        next_state = S_POR;
      end
    endcase
  end

  // The window may end before a daisy run command; remember it ended.
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      p1_tick_seen <= 1'b0;
      p1_restart   <= 1'b0;
    end else begin
      p1_restart <= state[0] & p1_tick;
      if (state[1] & p1_tick) begin
        p1_tick_seen <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Frames and sequence counters
  // ----------------------------------------------------------------
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state            <= S_POR;
      nib              <= 6'd0;
      rep              <= 3'd0;
      half             <= 1'b0;
      rdy_cnt          <= 1'b0;
      p0_idx           <= 2'd0;
      p0_latch         <= 12'h000;
      frame_valid_o    <= 1'b0;
      frame_code_o     <= 10'h000;
      frame_sid_mask_o <= 4'h0;
      init_phase_o     <= 3'b001;
      init_done_flag_o <= 1'b0;
      prog_mode_o      <= 1'b0;
    end else begin
      state         <= next_state;
      frame_valid_o <= 1'b0;
      init_phase_o  <= {|next_state[6:4], next_state[3], |next_state[1:0]};
      prog_mode_o   <= next_state[2];
      if (err_slot || (state[7] && opp && p0_oor)) begin
        frame_valid_o    <= 1'b1;
        frame_code_o     <= `CODE_P0_ERR;
        frame_sid_mask_o <= sid_mask;
      end else if (seq_opp) begin
        case (state)
          S_P2: begin
            frame_valid_o    <= 1'b1;
            frame_code_o     <= half ? data_code : id_code;
            frame_sid_mask_o <= sid_mask;
            half             <= ~half;
            if (half) begin
              if (rep == k_last) begin
                rep <= 3'd0;
                nib <= nib + 6'd1;
              end else begin
                rep <= rep + 3'd1;
              end
            end
          end
          S_BUSY: begin
            frame_valid_o    <= 1'b1;
            frame_sid_mask_o <= sid_mask;
            frame_code_o     <= st_complete ? ready_code : `CODE_BUSY;
            rdy_cnt          <= st_complete;
          end
          S_READY: begin
            frame_valid_o    <= 1'b1;
            frame_sid_mask_o <= sid_mask;
            frame_code_o     <= ready_code;
            rdy_cnt          <= 1'b1;
            if (rdy_cnt) begin
              p0_latch <= reference_pressure_i;
            end
          end
          S_P0: begin
            frame_valid_o    <= 1'b1;
            frame_sid_mask_o <= sid_mask;
            frame_code_o     <= p0_code;
            p0_idx           <= p0_idx + 2'd1;
            if (p0_idx == 2'd3) begin
              init_done_flag_o <= 1'b1;
            end
          end
          default: begin
            frame_valid_o <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Pressure range error
  // ----------------------------------------------------------------
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      p0_err_pend <= 1'b0;
      p0_error_o  <= 1'b0;
    end else if (state[7]) begin
      p0_err_pend <= 1'b0;
      if (opp) begin
        p0_error_o <= p0_oor;
      end
    end else if (hold_tick && p0_oor) begin
      p0_err_pend <= 1'b1;
      p0_error_o  <= 1'b1;
    end else if (err_slot) begin
      p0_err_pend <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Self-test control
  // ----------------------------------------------------------------
  wire p1_leave = state[1] & next_state[3];

  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st_run           <= 1'b0;
      st_complete      <= 1'b0;
      st_tries         <= 4'd0;
      selftest_start_o <= 1'b0;
      selftest_error_o <= 1'b0;
    end else begin
      selftest_start_o <= 1'b0;
      if (p1_leave) begin
        st_run           <= 1'b1;
        selftest_start_o <= 1'b1;
      end else if (st_run && selftest_done_i) begin
        if (selftest_pass_i) begin
          st_run      <= 1'b0;
          st_complete <= 1'b1;
        end else if (st_tries < selftest_retry_limit_i) begin
          st_tries         <= st_tries + 4'd1;
          selftest_start_o <= 1'b1;
        end else begin
          st_run           <= 1'b0;
          st_complete      <= 1'b1;
          selftest_error_o <= 1'b1;
        end
      end
    end
  end

endmodule // psi5_init_sequencer

// File: dv/psi5_ecu_model.sv
// Receiver-side model that issues sync pulses while the bus runs synchronously.
`timescale 1ns/10ps

module psi5_ecu_model #(
  parameter PERIOD = 8
) (
  // Clock and control
  input  wire mclk_i,
  input  wire run_i,
  // Bus
  output reg  sync_pulse_o
);
  integer cnt = 0;

  initial sync_pulse_o = 1'b0;

  // The pulse is two cycles wide so that the device's synchroniser always sees it.
  always @(negedge mclk_i) begin
    cnt = (cnt + 1) % PERIOD;
    sync_pulse_o <= run_i && (cnt < 2);
  end
endmodule // psi5_ecu_model

// File: dv/psi5_init_sequencer_chk.sv
// Port assertions for the PSI5 initialization sequencer.
`timescale 1ns/10ps

module psi5_init_sequencer_chk #(
  parameter [27:0] P0_HOLD_CYC = 28'd2000
) (
  // Clock and reset
  input wire       mclk_i,
  input wire       sys_rst_i,
  // Configuration
  input wire       sync_mode_i,
  input wire       daisy_chain_i,
  input wire [3:0] sid_enable_i,
  // Outputs
  input wire       selftest_start_o,
  input wire       frame_valid_o,
  input wire [9:0] frame_code_o,
  input wire [3:0] frame_sid_mask_o,
  input wire [2:0] init_phase_o,
  input wire       init_done_flag_o,
  input wire       prog_mode_o,
  input wire       p0_error_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  // ----------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------
  reg        st_prev;
  reg        last_id;
  reg [27:0] age;

  always @(posedge mclk_i) begin
    st_prev <= selftest_start_o;
    if (sys_rst_i) begin
      age     <= 28'd0;
      last_id <= 1'b0;
    end else begin
      if (age != 28'hfffffff) age <= age + 28'd1;
      if (frame_valid_o && frame_code_o != 10'h1f4)
        last_id <= (init_phase_o == 3'b010) && (frame_code_o[9:4] == 6'h20);
    end
  end

  sequence enter_p2_s;
    init_phase_o == 3'b010 && $past(init_phase_o) == 3'b001;
  endsequence
  sequence st_kick_s;
    ##[0:1] (selftest_start_o || st_prev);
  endsequence

  silent_phase_one_a: assert property (init_phase_o == 3'b001 |-> !frame_valid_o)
    else $error("frame sent in phase one");
  phase_order_a: assert property (init_phase_o == 3'b100 |->
    $past(init_phase_o) inside {3'b010, 3'b100}) else $error("phase three out of order");
  done_exit_a: assert property ($rose(init_done_flag_o) |-> init_phase_o == 3'b000)
    else $error("done flag set inside a phase");
  done_sticky_a: assert property (init_done_flag_o |=> init_done_flag_o)
    else $error("done flag dropped");
  async_mask_a: assert property (frame_valid_o && !sync_mode_i |-> frame_sid_mask_o == 4'h1)
    else $error("async frame not for source zero");
  sync_mask_a: assert property (frame_valid_o && sync_mode_i && !daisy_chain_i |->
    frame_sid_mask_o == sid_enable_i) else $error("sync frame mask wrong");
  daisy_mask_a: assert property (frame_valid_o && daisy_chain_i |-> frame_sid_mask_o == 4'h1)
    else $error("daisy frame not for source zero");
  p0_hold_a: assert property ($rose(p0_error_o) |-> age >= P0_HOLD_CYC - 28'd2)
    else $error("pressure error before hold-off");
  prog_silent_a: assert property (prog_mode_o |-> !frame_valid_o && init_phase_o == 3'b000)
    else $error("activity in programming mode");
  id_then_data_a: assert property (frame_valid_o && last_id &&
    init_phase_o == 3'b010 && frame_code_o != 10'h1f4 |-> frame_code_o[9:4] == 6'h21)
    else $error("identifier not followed by data");
  selftest_kick_a: assert property (enter_p2_s |-> st_kick_s)
    else $error("self-test not started");
  phase3_codes_a: assert property (frame_valid_o && init_phase_o == 3'b100 |->
    frame_code_o[9:5] == 5'b10000 || frame_code_o inside {10'h1e8, 10'h1e7, 10'h1e6, 10'h1ea, 10'h1f4})
    else $error("bad phase three code");
  one_frame_a: assert property (frame_valid_o |=> !frame_valid_o)
    else $error("frame pulse too long");
endmodule // psi5_init_sequencer_chk

bind psi5_init_sequencer psi5_init_sequencer_chk #(.P0_HOLD_CYC(P0_HOLD_CYC))
  i_psi5_init_sequencer_chk (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
  .sync_mode_i(sync_mode_i), .daisy_chain_i(daisy_chain_i), .sid_enable_i(sid_enable_i),
  .selftest_start_o(selftest_start_o), .frame_valid_o(frame_valid_o),
  .frame_code_o(frame_code_o), .frame_sid_mask_o(frame_sid_mask_o),
  .init_phase_o(init_phase_o), .init_done_flag_o(init_done_flag_o),
  .prog_mode_o(prog_mode_o), .p0_error_o(p0_error_o));

// File: dv/psi5_init_sequencer_test.sv
// Self-checking bench for the PSI5 initialization sequencer.
`timescale 1ns/10ps
`define CHECK(a, b, m) begin n_tests = n_tests + 1; if ((a) !== (b)) begin \
  err_count = err_count + 1; $display("FAIL %0t %s", $time, m); end end

module psi5_init_sequencer_test;
  // ----------------------------------------------------------------
  // Stimulus and model state
  // ----------------------------------------------------------------
  reg         mclk_i = 1'b0, sys_rst_i = 1'b1, smode = 1'b0, daisy = 1'b0, ext = 1'b0;
  reg         unl = 1'b0, pme = 1'b0, drun = 1'b0, st_done = 1'b0, st_pass = 1'b0;
  reg  [3:0]  sid_en = 4'h1, retry = 4'h2;
  reg  [71:0] user = 72'h0;
  reg  [39:0] sn = 40'h0;
  reg  [15:0] pn = 16'h0;
  reg  [11:0] p0 = 12'h0, p0_lo = 12'h0, p0_hi = 12'hfff, p0_lat;
  reg  [9:0]  q[$];
  wire        sync_p, st_start, st_err, fv, done, prog, p0_err;
  wire [9:0]  code;
  wire [3:0]  mask;
  wire [2:0]  phase;
  integer     err_count = 0, n_tests = 0, seed = 32'h0421, i;
  integer     fails = 0, att = 0, st_len = 5, stc = 0, rdy = 0, pcnt = 0, nf = 0;

  always #5 mclk_i = ~mclk_i;

  psi5_init_sequencer #(.POR_CYC(28'd20), .PME_CYC(28'd50), .ASYNC_CYC(28'd10),
    .P0_HOLD_CYC(28'd2000)) i_psi5_init_sequencer (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .sync_mode_i(smode), .daisy_chain_i(daisy),
    .sid_enable_i(sid_en), .phase2_extended_fields_i(ext), .selftest_retry_limit_i(retry),
    .unlocked_i(unl), .sync_pulse_i(sync_p), .pme_detect_i(pme), .daisy_run_i(drun),
    .user_info_bytes_i(user), .serial_number_bytes_i(sn), .part_number_bytes_i(pn),
    .reference_pressure_i(p0), .p0_low_i(p0_lo), .p0_high_i(p0_hi),
    .selftest_done_i(st_done), .selftest_pass_i(st_pass), .selftest_start_o(st_start),
    .selftest_error_o(st_err), .frame_valid_o(fv), .frame_code_o(code),
    .frame_sid_mask_o(mask), .init_phase_o(phase), .init_done_flag_o(done),
    .prog_mode_o(prog), .p0_error_o(p0_err));
  psi5_ecu_model #(.PERIOD(8)) i_psi5_ecu_model (.mclk_i(mclk_i),
    .run_i(smode && !sys_rst_i), .sync_pulse_o(sync_p));

  // ----------------------------------------------------------------
  // Reference model
  // ----------------------------------------------------------------
  function [3:0] nib(input integer n);
    if (n == 1) nib = user[3:0];
    else if (n == 2) nib = ext ? 4'h3 : 4'h2;
    else if (n == 3) nib = 4'h0;
    else if (n <= 13) nib = user[((n - 2) / 2) * 8 + (n % 2) * 4 +: 4];
    else if (n == 14) nib = user[51:48];
    else if (n <= 18) nib = user[((n - 1) / 2) * 8 + ((n + 1) % 2) * 4 +: 4];
    else if (n <= 28) nib = sn[39 - 4 * (n - 19) -: 4];
    else if (n <= 31) nib = pn[127 - 4 * n -: 4];
    else if (n == 32) nib = user[55:52];
    else nib = 4'h0;
  endfunction

  task start(input s, input d, input e, input integer f, input integer len);
    integer n, r;
    begin
      sys_rst_i = 1'b1;
      smode = s; daisy = d; ext = e; fails = f; st_len = len;
      att = 0; stc = 0; nf = 0; rdy = 0; pcnt = 0; drun = 1'b0;
      unl = 1'($random(seed));
      retry = 4'd1 + 4'({$random(seed)} % 15);
      sid_en = 4'd1 + 4'({$random(seed)} % 15);
      user = {8'($random(seed)), 32'($random(seed)), 32'($random(seed))};
      sn = {8'($random(seed)), 32'($random(seed))};
      pn = 16'($random(seed));
      p0 = 12'($random(seed));
      p0_lo = 12'h0;
      p0_hi = 12'hfff;
      q.delete();
      for (n = 1; n <= (ext ? 48 : 32); n = n + 1)
        for (r = 0; r < (smode ? 4 : 8); r = r + 1) begin
          q.push_back(10'h20f - 10'((n - 1) % 16));
          q.push_back(10'h21f - {6'h0, nib(n)});
        end
      repeat (10) @(negedge mclk_i);
      sys_rst_i = 1'b0;
    end
  endtask

  task wait_done(input integer lim);
    begin
      for (i = 0; i < lim && done !== 1'b1; i = i + 1) @(negedge mclk_i);
      repeat (20) @(negedge mclk_i);
      `CHECK(done, 1'b1, "init done flag")
      `CHECK(q.size() == 0 && pcnt == 4, 1'b1, "frame stream incomplete")
      `CHECK(att, fails + 1, "self-test attempts")
      `CHECK(phase, 3'b000, "normal mode")
    end
  endtask

  // Self-test engine and frame monitor, both driven on the falling edge.
  always @(negedge mclk_i) begin
    st_done <= 1'b0;
    if (st_start === 1'b1) begin
      att = att + 1;
      stc = st_len;
    end else if (stc > 0) begin
      stc = stc - 1;
      st_done <= (stc == 0);
      st_pass <= (att > fails);
    end
    if (!sys_rst_i && fv === 1'b1) begin
      nf = nf + 1;
      `CHECK(mask, (smode && !daisy) ? sid_en : 4'h1, "source mask")
      if (code === 10'h1f4 && pcnt < 4) begin
        `CHECK(p0_err, 1'b1, "held pressure error")
      end else if (q.size() > 0) begin
        `CHECK(code, q.pop_front(), "phase 2 code")
      end else if (code === 10'h1e8 && rdy == 0) begin
        nf = nf + 0;
      end else if (rdy < 2) begin
        `CHECK(code, unl ? 10'h1e6 : 10'h1e7, "ready code")
        rdy = rdy + 1;
        if (rdy == 2) begin
          p0_lat = p0;
          p0 <= 12'($random(seed));
        end
      end else if (pcnt < 4) begin
        `CHECK(code, {5'b10000, 2'(pcnt), p0_lat[11 - 3 * pcnt -: 3]}, "pressure")
        pcnt = pcnt + 1;
      end else begin
        `CHECK(code, 10'h1f4, "error frame")
      end
    end
  end

  // ----------------------------------------------------------------
  // Scenarios and verdict
  // ----------------------------------------------------------------
  task finish_test;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
        $display("NO MISMATCHES");
      end else begin
        $display("MISMATCHES SEEN");
      end
      $finish;
    end
  endtask

  initial begin
    start(0, 0, 0, 0, 5);
    for (i = 0; i < 200 && phase !== 3'b010; i = i + 1) @(negedge mclk_i);
    `CHECK(i >= 73 && i <= 76, 1'b1, "phase 1 length")
    for (i = 0; i < 9000 && phase !== 3'b100; i = i + 1) @(negedge mclk_i);
    `CHECK(i >= 5110 && i <= 5130, 1'b1, "phase 2 length")
    wait_done(3000);
    $display("async standard run done");
    start(0, 0, 0, 0, 5);
    repeat (40) @(negedge mclk_i);
    pme = 1'b1;
    @(negedge mclk_i);
    pme = 1'b0;
    repeat (200) @(negedge mclk_i);
    `CHECK(prog, 1'b1, "programming mode")
    `CHECK(nf, 0, "frames in programming mode")
    $display("programming entry run done");
    start(1, 0, 1, 1, 2000);
    p0_lo = 12'hfff;
    p0_hi = 12'h000;
    wait_done(12000);
    `CHECK(st_err, 1'b0, "self-test error flag")
    `CHECK(p0_err, 1'b1, "pressure error after hold")
    $display("sync extended run done");
    start(1, 1, 0, 0, 30);
    for (i = 0; i < 200 && phase !== 3'b010; i = i + 1) @(negedge mclk_i);
    repeat (30) @(negedge mclk_i);
    drun = 1'b1;
    wait_done(6000);
    p0 = 12'h800;
    p0_lo = 12'hfff;
    for (i = 0; i < 30 && p0_err !== 1'b1; i = i + 1) @(negedge mclk_i);
    `CHECK(p0_err, 1'b1, "pressure error in normal mode")
    repeat (20) @(negedge mclk_i);
    $display("daisy chain run done");
    finish_test;
  end

  initial begin
    repeat (30000) @(posedge mclk_i);
    err_count = err_count + 1;
    $display("FAIL %0t watchdog expired", $time);
    finish_test;
  end
endmodule // psi5_init_sequencer_test
